// ==== core/pdr_pkg.sv ====
// Purpose: Constants for the port dataset register group.
// Assumes: 16-bit byte address, 32-bit register words.
package pdr_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int DELAY_W = 64;
  localparam int BYTE_W = 8;
  localparam int HALF_W = 16;

  localparam logic [15:0] OFF_LIMIT = 16'h0220;
  localparam logic [15:0] OFF_CTRL = 16'h1200;
  localparam logic [15:0] OFF_DLY_HI = 16'h1204;
  localparam logic [15:0] OFF_DLY_LO = 16'h1208;
  localparam logic [15:0] OFF_STATE = 16'h120C;
  localparam logic [15:0] OFF_QUERY = 16'h1210;
  localparam logic [15:0] OFF_ADVERT = 16'h1214;
  localparam logic [15:0] OFF_SYNC = 16'h1218;
  localparam logic [15:0] OFF_SKEW = 16'h121C;

  localparam int CTRL_DONE_BIT = 31;
  localparam int CTRL_REQ_BIT = 30;
  localparam int CTRL_SKEW_BIT = 2;
  localparam int CTRL_RATE_BIT = 1;
  localparam int CTRL_METHOD_BIT = 0;

  localparam int HI_FIELD_LSB = 8;
  localparam int LO_FIELD_LSB = 0;
  localparam int SCALED_NS_SHIFT = 16;

  localparam logic [31:0] RESET_WORD = 32'h00000000;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [1:0] {
    PDR_SNAP_IDLE = 2'b01,
    PDR_SNAP_CAPTURE = 2'b10
  } pdr_snap_t;

endpackage : pdr_pkg

// ==== core/pdr_field_reg.sv ====
// Purpose: Software-written staging register of parameterised width.
// Assumes: Synchronous active-high reset, write strobe one cycle.
// Notes: With ENABLE low it is absent and reads zero.
`timescale 1ns/1ns
module pdr_field_reg #(
  parameter int WIDTH = 32,
  parameter bit ENABLE = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] value
);

  generate
    if (WIDTH < 1 || WIDTH > pdr_pkg::DATA_W) begin : g_bad_width
      $error("pdr_field_reg: WIDTH out of range");
    end
    if (ENABLE) begin : g_on
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          value <= '0;
        end else if (wr_en) begin
          value <= wdata;
        end
      end
    end else begin : g_off
      // Absent register: writes dropped, reads zero
      assign value = '0;
    end
  endgenerate

endmodule : pdr_field_reg

// ==== core/pdr_port_dataset_regs.sv ====
// Purpose: Port dataset register group of an ordinary clock.
// Assumes: Register port strobes are one-cycle, synchronous to clk.
// Notes: Read data returns one cycle after the read strobe.
`timescale 1ns/1ns
module pdr_port_dataset_regs #(
  parameter bit RUNTIME_RATE_OPTION = 1'b1,
  parameter logic [7:0] FIXED_DELAY_QUERY_LOG = 8'h00,
  parameter logic [7:0] FIXED_NEIGHBOUR_QUERY_LOG = 8'h00,
  parameter logic [7:0] FIXED_ANNOUNCE_TIMEOUT = 8'h03,
  parameter logic [7:0] FIXED_ANNOUNCE_LOG = 8'h01,
  parameter logic [7:0] FIXED_SYNC_LOG = 8'h00
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic [63:0] peer_delay_live,
  input wire logic [7:0] port_state_live,
  input wire logic tsn_profile_en,
  output logic [31:0] path_skew_ns,
  output logic path_skew_valid,
  output logic message_rate_valid,
  output logic delay_method_valid,
  output logic [7:0] delay_query_log_period,
  output logic [7:0] neighbour_query_log_period,
  output logic [7:0] announce_timeout,
  output logic [7:0] announce_log_period,
  output logic [7:0] sync_log_period,
  output logic neighbour_delay_invalid
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire logic hit_ctrl = reg_addr == pdr_pkg::OFF_CTRL;
  wire logic hit_dly_hi = reg_addr == pdr_pkg::OFF_DLY_HI;
  wire logic hit_dly_lo = reg_addr == pdr_pkg::OFF_DLY_LO;
  wire logic hit_state = reg_addr == pdr_pkg::OFF_STATE;
  wire logic hit_query = reg_addr == pdr_pkg::OFF_QUERY;
  wire logic hit_advert = reg_addr == pdr_pkg::OFF_ADVERT;
  wire logic hit_sync = reg_addr == pdr_pkg::OFF_SYNC;
  wire logic hit_skew = reg_addr == pdr_pkg::OFF_SKEW;
  wire logic hit_limit = reg_addr == pdr_pkg::OFF_LIMIT;

  wire logic wr_ctrl = reg_wr_en && hit_ctrl;
  wire logic wr_req = wr_ctrl && reg_wdata[pdr_pkg::CTRL_REQ_BIT];
  wire logic wr_skew_commit = wr_ctrl && reg_wdata[pdr_pkg::CTRL_SKEW_BIT];
  wire logic wr_rate_commit = wr_ctrl && reg_wdata[pdr_pkg::CTRL_RATE_BIT];

  generate
    if (pdr_pkg::DELAY_W != 2 * pdr_pkg::DATA_W) begin : g_bad_delay
      $error("pdr_port_dataset_regs: delay must span two words");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Staging registers written by software

  logic [15:0] query_stage;
  logic [15:0] advert_stage;
  logic [7:0] sync_stage;
  logic [31:0] skew_stage;
  logic [31:0] limit_stage;

  // Only the defined low bits are stored; upper bits are dropped
  pdr_field_reg #(.WIDTH(pdr_pkg::HALF_W), .ENABLE(RUNTIME_RATE_OPTION)) u_query (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(reg_wr_en && hit_query),
    .wdata(reg_wdata[15:0]),
    .value(query_stage)
  );

  pdr_field_reg #(.WIDTH(pdr_pkg::HALF_W), .ENABLE(RUNTIME_RATE_OPTION)) u_advert (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(reg_wr_en && hit_advert),
    .wdata(reg_wdata[15:0]),
    .value(advert_stage)
  );

  pdr_field_reg #(.WIDTH(pdr_pkg::BYTE_W), .ENABLE(RUNTIME_RATE_OPTION)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(reg_wr_en && hit_sync),
    .wdata(reg_wdata[7:0]),
    .value(sync_stage)
  );

  pdr_field_reg #(.WIDTH(pdr_pkg::DATA_W), .ENABLE(1'b1)) u_skew (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(reg_wr_en && hit_skew),
    .wdata(reg_wdata),
    .value(skew_stage)
  );

  pdr_field_reg #(.WIDTH(pdr_pkg::DATA_W), .ENABLE(1'b1)) u_limit (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(reg_wr_en && hit_limit),
    .wdata(reg_wdata),
    .value(limit_stage)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot handshake

  pdr_pkg::pdr_snap_t snap_q;
  pdr_pkg::pdr_snap_t snap_d;
  logic snap_done_q;
  logic [63:0] dly_snap_q;
  logic [7:0] state_snap_q;

  wire logic capturing = snap_q == pdr_pkg::PDR_SNAP_CAPTURE;

  // A request written during a capture queues one more capture
  always_comb begin
    snap_d = snap_q;
    unique case (snap_q)
      pdr_pkg::PDR_SNAP_IDLE: begin
        if (wr_req) begin
          snap_d = pdr_pkg::PDR_SNAP_CAPTURE;
        end
      end
      pdr_pkg::PDR_SNAP_CAPTURE: begin
        if (!wr_req) begin
          snap_d = pdr_pkg::PDR_SNAP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      snap_q <= pdr_pkg::PDR_SNAP_IDLE;
      snap_done_q <= 1'b0;
      dly_snap_q <= '0;
      state_snap_q <= pdr_pkg::RESET_BYTE;
    end else begin
      snap_q <= snap_d;
      // Capture sets done and wins over a clearing request
      if (capturing) begin
        snap_done_q <= 1'b1;
        dly_snap_q <= peer_delay_live;
        state_snap_q <= port_state_live;
      end else if (wr_req) begin
        snap_done_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Valid flags and adopted configuration

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      path_skew_valid <= 1'b0;
      message_rate_valid <= 1'b0;
      delay_method_valid <= 1'b0;
    end else if (wr_ctrl) begin
      path_skew_valid <= reg_wdata[pdr_pkg::CTRL_SKEW_BIT];
      message_rate_valid <= reg_wdata[pdr_pkg::CTRL_RATE_BIT];
      delay_method_valid <= reg_wdata[pdr_pkg::CTRL_METHOD_BIT];
    end
  end

  // Staged skew and intervals reach the engine only on a valid commit; the limit applies as soon as written
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      path_skew_ns <= pdr_pkg::RESET_WORD;
    end else if (wr_skew_commit) begin
      path_skew_ns <= skew_stage;
    end
  end

  // Without the runtime option the core's fixed periods stay in force
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      delay_query_log_period <= FIXED_DELAY_QUERY_LOG;
      neighbour_query_log_period <= FIXED_NEIGHBOUR_QUERY_LOG;
      announce_timeout <= FIXED_ANNOUNCE_TIMEOUT;
      announce_log_period <= FIXED_ANNOUNCE_LOG;
      sync_log_period <= FIXED_SYNC_LOG;
    end else if (wr_rate_commit && RUNTIME_RATE_OPTION) begin
      delay_query_log_period <= query_stage[15:pdr_pkg::HI_FIELD_LSB];
      neighbour_query_log_period <= query_stage[7:pdr_pkg::LO_FIELD_LSB];
      announce_timeout <= advert_stage[15:pdr_pkg::HI_FIELD_LSB];
      announce_log_period <= advert_stage[7:pdr_pkg::LO_FIELD_LSB];
      sync_log_period <= sync_stage;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Neighbour delay limit, scaled ns reduced to whole ns

  wire logic [47:0] delay_whole_ns = peer_delay_live[63:pdr_pkg::SCALED_NS_SHIFT];
  wire logic over_limit = delay_whole_ns > {16'h0000, limit_stage};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      neighbour_delay_invalid <= 1'b0;
    end else begin
      neighbour_delay_invalid <= tsn_profile_en && over_limit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; unmapped addresses return zero

  wire logic [31:0] ctrl_word = {snap_done_q, capturing, 27'h0000000,
    path_skew_valid, message_rate_valid, delay_method_valid};
  wire logic [31:0] rd_word =
    hit_ctrl ? ctrl_word :
    hit_dly_hi ? dly_snap_q[63:32] :
    hit_dly_lo ? dly_snap_q[31:0] :
    hit_state ? {24'h000000, state_snap_q} :
    hit_query ? {16'h0000, query_stage} :
    hit_advert ? {16'h0000, advert_stage} :
    hit_sync ? {24'h000000, sync_stage} :
    hit_skew ? skew_stage :
    hit_limit ? limit_stage :
    pdr_pkg::RESET_WORD;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= pdr_pkg::RESET_WORD;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      reg_rdata <= reg_rd_en ? rd_word : pdr_pkg::RESET_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_req_taken;
    wr_req && !capturing;
  endsequence

  sequence s_capture_done;
    capturing ##1 snap_done_q;
  endsequence

  a_snap_handshake: assert property (@(posedge clk) disable iff (sys_rst)
    s_req_taken |=> s_capture_done)
    else $error("snapshot did not complete two cycles after request");

  a_req_autoclear: assert property (@(posedge clk) disable iff (sys_rst)
    (capturing && !wr_req) |=> !capturing && !ctrl_word[pdr_pkg::CTRL_REQ_BIT])
    else $error("request bit not cleared after capture");

  a_done_cleared: assert property (@(posedge clk) disable iff (sys_rst)
    s_req_taken |=> !snap_done_q)
    else $error("done flag not cleared by new request");

  a_snap_capture: assert property (@(posedge clk) disable iff (sys_rst)
    capturing |=> dly_snap_q == $past(peer_delay_live)
      && state_snap_q == $past(port_state_live))
    else $error("snapshot did not capture live values");

  a_skew_commit: assert property (@(posedge clk) disable iff (sys_rst)
    wr_skew_commit |=> path_skew_ns == $past(skew_stage) && path_skew_valid)
    else $error("path skew not adopted on valid commit");

  a_skew_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !wr_skew_commit |=> $stable(path_skew_ns))
    else $error("path skew changed without commit");

  a_fixed_rates: assert property (@(posedge clk) disable iff (sys_rst)
    !RUNTIME_RATE_OPTION |-> sync_log_period == FIXED_SYNC_LOG && query_stage == 16'h0000)
    else $error("intervals not fixed without runtime option");

  a_limit_check: assert property (@(posedge clk) disable iff (sys_rst)
    neighbour_delay_invalid == $past(tsn_profile_en && over_limit))
    else $error("neighbour delay invalid flag wrong");

  a_state_read: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd_en && hit_state) |=> reg_rd_valid && reg_rdata[31:8] == 24'h000000
      && reg_rdata[7:0] == $past(state_snap_q))
    else $error("port state read wrong or reserved bits set");

  a_delay_hi_read: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd_en && hit_dly_hi) |=> reg_rdata == $past(dly_snap_q[63:32]))
    else $error("neighbour delay high word read wrong");

  a_rate_commit: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_rate_commit && RUNTIME_RATE_OPTION) |=>
      delay_query_log_period == $past(query_stage[15:8])
      && neighbour_query_log_period == $past(query_stage[7:0])
      && announce_timeout == $past(advert_stage[15:8])
      && announce_log_period == $past(advert_stage[7:0])
      && sync_log_period == $past(sync_stage))
    else $error("message intervals not adopted on valid commit");

  a_rate_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !wr_rate_commit |=> $stable(sync_log_period) && $stable(delay_query_log_period))
    else $error("message intervals changed without commit");

  a_ctrl_reserved: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd_en && hit_ctrl) |=> reg_rdata[29:3] == 27'h0000000)
    else $error("reserved control bits read nonzero");

endmodule : pdr_port_dataset_regs

// ==== verif/tb_pdr_port_dataset_regs.sv ====
// Purpose: Self-checking bench for the port dataset register group.
// Assumes: One-cycle strobes, read data one cycle after the read strobe.
// Notes: A second instance without the runtime rate option shares all inputs.
`timescale 1ns/1ns
module tb_pdr_port_dataset_regs;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic [63:0] dly_live = 64'h0000000000000000;
  logic [7:0] state_live = 8'h00;
  logic tsn_en = 1'b0;
  logic [31:0] rdata, rdata_fx, got, got_fx, skew;
  logic rd_valid, rd_valid_fx, skew_v, rate_v, meth_v, dly_bad;
  logic [7:0] dq, nq, at, al, sl, dq_fx, nq_fx, at_fx, al_fx, sl_fx;
  int error_cnt = 0;
  int num_checks = 0;
  logic [15:0] offs [9] = '{pdr_pkg::OFF_LIMIT, pdr_pkg::OFF_CTRL, pdr_pkg::OFF_DLY_HI,
    pdr_pkg::OFF_DLY_LO, pdr_pkg::OFF_STATE, pdr_pkg::OFF_QUERY, pdr_pkg::OFF_ADVERT,
    pdr_pkg::OFF_SYNC, pdr_pkg::OFF_SKEW};
  // Staged field table: offset, written word, expected read-back
  logic [15:0] f_off [5] = '{pdr_pkg::OFF_QUERY, pdr_pkg::OFF_ADVERT, pdr_pkg::OFF_SYNC,
    pdr_pkg::OFF_SKEW, pdr_pkg::OFF_LIMIT};
  logic [31:0] f_wr [5] = '{32'hFFFF81C3, 32'hAAAA05FE, 32'h123456FD, 32'hFFFFFF85,
    32'h000000FF};
  logic [31:0] f_exp [5] = '{32'h000081C3, 32'h000005FE, 32'h000000FD, 32'hFFFFFF85,
    32'h000000FF};

  pdr_port_dataset_regs dut (.clk(clk), .sys_rst(sys_rst), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rd_valid(rd_valid), .peer_delay_live(dly_live), .port_state_live(state_live),
    .tsn_profile_en(tsn_en), .path_skew_ns(skew), .path_skew_valid(skew_v),
    .message_rate_valid(rate_v), .delay_method_valid(meth_v),
    .delay_query_log_period(dq), .neighbour_query_log_period(nq), .announce_timeout(at),
    .announce_log_period(al), .sync_log_period(sl), .neighbour_delay_invalid(dly_bad));

  pdr_port_dataset_regs #(.RUNTIME_RATE_OPTION(1'b0)) dut_fixed (.clk(clk),
    .sys_rst(sys_rst), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata_fx), .reg_rd_valid(rd_valid_fx),
    .peer_delay_live(dly_live), .port_state_live(state_live), .tsn_profile_en(tsn_en),
    .path_skew_ns(), .path_skew_valid(), .message_rate_valid(), .delay_method_valid(),
    .delay_query_log_period(dq_fx), .neighbour_query_log_period(nq_fx),
    .announce_timeout(at_fx), .announce_log_period(al_fx), .sync_log_period(sl_fx),
    .neighbour_delay_invalid());

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    wr_en = 1'b0;
  endtask : reg_write

  // Valid pulse stands one cycle only, so it is sampled right after its edge
  task automatic reg_read(input logic [15:0] a);
    @(posedge clk);
    #1;
    rd_en = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    got = rdata;
    got_fx = rdata_fx;
    check("rd_valid", 32'h00000003, {30'h0, rd_valid, rd_valid_fx});
  endtask : reg_read

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // Read issued back to back with the request sees the capture cycle
  task automatic snap(input logic [63:0] d, input logic [7:0] s);
    dly_live = d;
    state_live = s;
    @(posedge clk);
    #1;
    wr_en = 1'b1;
    addr = pdr_pkg::OFF_CTRL;
    wdata = 32'h40000000;
    @(posedge clk);
    #1;
    wr_en = 1'b0;
    rd_en = 1'b1;
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    check("ctrl during capture", 32'h40000000, rdata); // Done cleared, request up
    dly_live = ~d;
    state_live = ~s;
    reg_read(pdr_pkg::OFF_CTRL);
    check("ctrl after capture", 32'h80000000, got); // Done set, request cleared
    reg_read(pdr_pkg::OFF_DLY_HI);
    check("delay high", d[63:32], got); // Captured high word
    reg_read(pdr_pkg::OFF_DLY_LO);
    check("delay low", d[31:0], got); // Captured low word
    reg_read(pdr_pkg::OFF_STATE);
    check("port state", {24'h0, s}, got); // Low byte only
  endtask : snap

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    error_cnt++;
    $display("[FAIL] watchdog expected done seen hang");
    final_report();
  end

  initial begin
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 9; i++) begin
      reg_read(offs[i]);
      check("reset word", 32'h00000000, got); // Every mapped register resets to zero
    end
    check("fixed timeout", 32'h00000003, {24'h0, at_fx}); // Core-fixed interval
    reg_read(16'h1300);
    check("unmapped", 32'h00000000, got); // Unmapped reads zero
    for (int i = 0; i < 5; i++) begin
      reg_write(f_off[i], f_wr[i]);
      reg_read(f_off[i]);
      check("field readback", f_exp[i], got); // Fields and masks
      if (i < 3) begin
        check("fixed interval reg", 32'h00000000, got_fx); // Absent without option
      end
    end
    check("skew before commit", 32'h00000000, skew); // Staging alone adopts nothing
    check("query before commit", 32'h00000000, {24'h0, dq}); // Staging alone
    reg_write(pdr_pkg::OFF_CTRL, 32'h00000004);
    settle();
    check("skew adopted", 32'hFFFFFF85, skew); // Signed ns adopted on commit
    check("skew valid", 32'h00000001, {31'h0, skew_v}); // Commit flag
    check("query not adopted", 32'h00000000, {24'h0, dq}); // Needs its own flag
    reg_write(pdr_pkg::OFF_CTRL, 32'h00000007);
    settle();
    check("query log", 32'h00000081, {24'h0, dq}); // Bits 15:8
    check("neighbour log", 32'h000000C3, {24'h0, nq}); // Bits 7:0
    check("announce timeout", 32'h00000005, {24'h0, at}); // Bits 15:8
    check("announce log", 32'h000000FE, {24'h0, al}); // Bits 7:0
    check("sync log", 32'h000000FD, {24'h0, sl}); // Low byte
    check("flags", 32'h00000007, {29'h0, skew_v, rate_v, meth_v}); // All three flags
    check("fixed intervals", 32'h00000301, {dq_fx, nq_fx, at_fx, al_fx}); // Unchanged
    check("fixed sync", 32'h00000000, {24'h0, sl_fx}); // Unchanged without option
    reg_read(pdr_pkg::OFF_CTRL);
    check("ctrl flags", 32'h00000007, got); // Flags read back as written
    reg_write(pdr_pkg::OFF_CTRL, 32'h3FFFFFFF); // Reserved bits written high
    reg_read(pdr_pkg::OFF_CTRL);
    check("ctrl reserved", 32'h00000007, got); // Reserved bits read zero
    reg_write(pdr_pkg::OFF_DLY_HI, 32'hFFFFFFFF);
    reg_read(pdr_pkg::OFF_DLY_HI);
    check("delay high write", 32'h00000000, got); // Read-only register
    dly_live = 64'h0000000001001234;
    settle();
    check("limit profile off", 32'h00000000, {31'h0, dly_bad}); // Profile gates
    tsn_en = 1'b1;
    settle();
    check("limit exceeded", 32'h00000001, {31'h0, dly_bad}); // 256 ns above 255
    reg_write(pdr_pkg::OFF_LIMIT, 32'h00000100);
    settle();
    check("limit equal", 32'h00000000, {31'h0, dly_bad}); // Equal still valid
    snap(64'h0102030405060708, 8'h06);
    snap(64'hF0E0D0C0B0A09080, 8'h03);
    final_report();
  end
endmodule : tb_pdr_port_dataset_regs
